// file: pkg/ccs_defs.svh
// Register offsets, field positions, reset values and delay figures of the clock switch
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

`define CCS_OFF_PCC 8'h00
`define CCS_OFF_MCM 8'h04
`define CCS_OFF_MOC 8'h08
`define CCS_OFF_CLOCK_OP_MODE_REG 8'h0C
`define CCS_OFF_RCM 8'h10

`define CCS_PCC_DIV_LSB 0
`define CCS_PCC_DIV_MSB 2
`define CCS_PCC_SUB_SEL 4
`define CCS_PCC_SUB_STS 5
`define CCS_MCM_SRC_SEL 0
`define CCS_MCM_SRC_STS 1
`define CCS_MCM_HS_SEL 2
`define CCS_MOC_MAIN_STOP 7
`define CCS_OSC_EXT_SEL 7
`define CCS_OSC_MAIN_EN 6
`define CCS_OSC_SUB_EN 4
`define CCS_RCM_INT_STOP 0
`define CCS_RCM_INT_STABLE 7

`define CCS_RST_DIV 3'h0
`define CCS_RST_MAIN_STOP 1'b1
`define CCS_DIV_MAX 3'h4

// Delay figures in old CPU clocks
`define CCS_DIV_BASE_CLKS 16
`define CCS_LEAVE_SUB_CLKS 2

`endif

// file: pkg/ccs_pkg.sv
// Types shared by the clock switch modules
package ccs_pkg;

    typedef struct packed {
        logic ext_main_select;
        logic main_osc_enable;
        logic sub_osc_enable;
        logic main_osc_stop;
        logic internal_osc_stop;
    } ccs_osc_ctrl_type;

    typedef struct packed {
        logic cpu_sub_status;
        logic main_src_status;
        logic [2:0] main_divider_field;
    } ccs_clk_state_type;

endpackage : ccs_pkg

// file: design/ccs_delay_counter.sv
// Switchover delay counter: done pulses N cycles after a start with load N
`timescale 1ns/1ns
module ccs_delay_counter #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic [CNT_W-1:0] load_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    import ccs_pkg::*;

    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= '0;
        else if (start_i)
            cnt_reg <= load_i;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    assign busy_o = (cnt_reg != '0);
    assign done_o = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

    AST_DONE_AFTER_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i && load_i == 1 |=> done_o)
        else $error("one-cycle delay did not finish");
endmodule : ccs_delay_counter

// file: design/ccs_clock_switch.sv
// CPU clock selection, delayed switchover and oscillator control with a Wishbone register port
//
// What this block does
// - Processor clock register holds divider in bits 0-2 and sub select in bit 4.
// - After a processor clock write the old clock runs for a set delay.
// - Divider change on main delays 16,8,4,2,1 old clocks; any change made on sub delays 2.
// - Main to sub delay is 2fxp/fsub scaled by old divider, rounded up.
// - Bit 5 of the processor clock register reports CPU running on sub clock.
// - Main mode register bit 0 selects main source, bit 1 reports it.
// - A main source change takes effect after a delay in old main clocks.
// - Main source delay is 1+2frh/fxh or 1+2fxh/frh clocks, truncated.
// - High speed select must be set first and changes only once per reset.
// - Clock mode register holds external select 7, main enable 6, sub enable 4.
// - Main oscillator control register holds main stop in bit 7.
// - Internal oscillator register holds stop in bit 0 and stable in bit 7.
`timescale 1ns/1ns
`include "ccs_defs.svh"
module ccs_clock_switch #(
    parameter int CNT_W = 16,
    parameter int FXP_HZ = 10000000,
    parameter int FSUB_HZ = 32768,
    parameter int FRH_KHZ = 8000,
    parameter int FXH_KHZ = 10000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator pins and controls
    input wire logic internal_osc_stable_i,
    output ccs_pkg::ccs_osc_ctrl_type osc_ctrl_o,
    output logic hs_system_select_o,
    // Active clock selection
    output ccs_pkg::ccs_clk_state_type clk_state_o
);
    import ccs_pkg::*;

    // Main source delays, fraction discarded
    localparam int MCS_UP_CLKS = 1 + (2 * FRH_KHZ) / FXH_KHZ;
    localparam int MCS_DOWN_CLKS = 1 + (2 * FXH_KHZ) / FRH_KHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Delay figures

    function automatic logic [CNT_W-1:0] main_to_sub_clks(input logic [2:0] div);
        longint den;
        den = longint'(FSUB_HZ) << div;
        return CNT_W'((2 * longint'(FXP_HZ) + den - 1) / den);
    endfunction : main_to_sub_clks

    function automatic logic [CNT_W-1:0] div_change_clks(input logic [2:0] div);
        if (div > `CCS_DIV_MAX)
            return CNT_W'(1);
        return CNT_W'(`CCS_DIV_BASE_CLKS >> div);
    endfunction : div_change_clks

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic ack_reg;
    logic [31:0] rd_data_reg;
    logic [2:0] req_div_reg;
    logic req_sub_reg;
    logic [2:0] act_div_reg;
    logic cpu_sub_reg;
    logic src_sel_reg;
    logic src_sts_reg;
    logic hs_sel_reg;
    logic hs_used_reg;
    ccs_osc_ctrl_type osc_reg;
    logic stable_meta_reg;
    logic stable_sync_reg;
    logic wr_en;
    logic [7:0] word_adr;
    logic pcc_start;
    logic pcc_busy;
    logic pcc_done;
    logic [CNT_W-1:0] pcc_load;
    logic mcs_start;
    logic mcs_busy;
    logic mcs_done;
    logic [CNT_W-1:0] mcs_load;

    assign word_adr = {wb_adr_i[7:2], 2'b00};
    // Narrow registers sit in byte lane 0
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone: one wait state, ack dropped the cycle after it is given

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_data_reg <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !ack_reg)
        begin
            rd_data_reg <= 32'h0000_0000;
            case (word_adr)
                `CCS_OFF_PCC:
                begin
                    rd_data_reg[`CCS_PCC_DIV_MSB:`CCS_PCC_DIV_LSB] <= req_div_reg;
                    rd_data_reg[`CCS_PCC_SUB_SEL] <= req_sub_reg;
                    rd_data_reg[`CCS_PCC_SUB_STS] <= cpu_sub_reg;
                end
                `CCS_OFF_MCM:
                begin
                    rd_data_reg[`CCS_MCM_SRC_SEL] <= src_sel_reg;
                    rd_data_reg[`CCS_MCM_SRC_STS] <= src_sts_reg;
                    rd_data_reg[`CCS_MCM_HS_SEL] <= hs_sel_reg;
                end
                `CCS_OFF_MOC:
                    rd_data_reg[`CCS_MOC_MAIN_STOP] <= osc_reg.main_osc_stop;
                `CCS_OFF_CLOCK_OP_MODE_REG:
                begin
                    rd_data_reg[`CCS_OSC_EXT_SEL] <= osc_reg.ext_main_select;
                    rd_data_reg[`CCS_OSC_MAIN_EN] <= osc_reg.main_osc_enable;
                    rd_data_reg[`CCS_OSC_SUB_EN] <= osc_reg.sub_osc_enable;
                end
                `CCS_OFF_RCM:
                begin
                    rd_data_reg[`CCS_RCM_INT_STOP] <= osc_reg.internal_osc_stop;
                    rd_data_reg[`CCS_RCM_INT_STABLE] <= stable_sync_reg;
                end
                default:
                    rd_data_reg <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written control bits

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_div_reg <= `CCS_RST_DIV;
            req_sub_reg <= 1'b0;
        end
        else if (wr_en && word_adr == `CCS_OFF_PCC)
        begin
            req_div_reg <= wb_dat_i[`CCS_PCC_DIV_MSB:`CCS_PCC_DIV_LSB];
            req_sub_reg <= wb_dat_i[`CCS_PCC_SUB_SEL];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_sel_reg <= 1'b0;
            hs_sel_reg <= 1'b0;
            hs_used_reg <= 1'b0;
        end
        else if (wr_en && word_adr == `CCS_OFF_MCM)
        begin
            src_sel_reg <= wb_dat_i[`CCS_MCM_SRC_SEL];
            // Only the first change after reset is taken; later ones are dropped
            if (!hs_used_reg && wb_dat_i[`CCS_MCM_HS_SEL] != hs_sel_reg)
            begin
                hs_sel_reg <= wb_dat_i[`CCS_MCM_HS_SEL];
                hs_used_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_reg <= '0;
            osc_reg.main_osc_stop <= `CCS_RST_MAIN_STOP;
        end
        else if (wr_en)
        begin
            case (word_adr)
                `CCS_OFF_MOC:
                    osc_reg.main_osc_stop <= wb_dat_i[`CCS_MOC_MAIN_STOP];
                `CCS_OFF_CLOCK_OP_MODE_REG:
                begin
                    osc_reg.ext_main_select <= wb_dat_i[`CCS_OSC_EXT_SEL];
                    osc_reg.main_osc_enable <= wb_dat_i[`CCS_OSC_MAIN_EN];
                    osc_reg.sub_osc_enable <= wb_dat_i[`CCS_OSC_SUB_EN];
                end
                `CCS_OFF_RCM:
                    osc_reg.internal_osc_stop <= wb_dat_i[`CCS_RCM_INT_STOP];
                default:
                    osc_reg <= osc_reg;
            endcase
        end
    end

    // Stable flag comes from the analog oscillator, so it is synchronised
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stable_meta_reg <= 1'b0;
            stable_sync_reg <= 1'b0;
        end
        else
        begin
            stable_meta_reg <= internal_osc_stable_i;
            stable_sync_reg <= stable_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU clock switchover: delay counted in old CPU clocks

    // A rewrite landing before the edge that ends a delay is applied at that edge, so the mux changes once
    assign pcc_start = !pcc_busy && (req_div_reg != act_div_reg || req_sub_reg != cpu_sub_reg);

    always_comb
    begin
        if (cpu_sub_reg)
            pcc_load = CNT_W'(`CCS_LEAVE_SUB_CLKS);
        else if (req_sub_reg)
            pcc_load = main_to_sub_clks(act_div_reg);
        else
            pcc_load = div_change_clks(act_div_reg);
    end

    ccs_delay_counter #(
        .CNT_W(CNT_W)
    ) u_pcc_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(pcc_start),
        .load_i(pcc_load),
        .busy_o(pcc_busy),
        .done_o(pcc_done)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            act_div_reg <= `CCS_RST_DIV;
            cpu_sub_reg <= 1'b0;
        end
        else if (pcc_done)
        begin
            act_div_reg <= req_div_reg;
            cpu_sub_reg <= req_sub_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main source switchover: delay counted in old main clocks

    // Moving to the high-speed clock waits until hs_system_select is set
    assign mcs_start = !mcs_busy && src_sel_reg != src_sts_reg && (!src_sel_reg || hs_sel_reg);
    assign mcs_load = src_sts_reg ? CNT_W'(MCS_DOWN_CLKS) : CNT_W'(MCS_UP_CLKS);

    ccs_delay_counter #(
        .CNT_W(CNT_W)
    ) u_mcs_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(mcs_start),
        .load_i(mcs_load),
        .busy_o(mcs_busy),
        .done_o(mcs_done)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            src_sts_reg <= 1'b0;
        else if (mcs_done && (!src_sel_reg || hs_sel_reg))
            src_sts_reg <= src_sel_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rd_data_reg;
    assign osc_ctrl_o = osc_reg;
    assign hs_system_select_o = hs_sel_reg;
    assign clk_state_o = '{cpu_sub_status: cpu_sub_reg, main_src_status: src_sts_reg,
                           main_divider_field: act_div_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_LEAVE_SUB_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
        pcc_start && cpu_sub_reg |=> !pcc_done ##1 pcc_done)
        else $error("leaving sub clock did not take two clocks");

    AST_DIV0_SIXTEEN: assert property (@(posedge clk_i) disable iff (rst_i)
        pcc_start && !cpu_sub_reg && !req_sub_reg && act_div_reg == 3'h0 |-> pcc_load == 16)
        else $error("divider change from 000 not sixteen clocks");

    AST_MAIN_TO_SUB: assert property (@(posedge clk_i) disable iff (rst_i)
        pcc_start && !cpu_sub_reg && req_sub_reg |-> pcc_load == main_to_sub_clks(act_div_reg) && pcc_load != 0)
        else $error("main to sub delay wrong");

    AST_OLD_CLOCK_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        pcc_start |=> $stable(cpu_sub_reg) && $stable(act_div_reg))
        else $error("CPU clock changed without delay");

    AST_SUB_STATUS_APPLY: assert property (@(posedge clk_i) disable iff (rst_i)
        pcc_done |=> cpu_sub_reg == $past(req_sub_reg))
        else $error("sub status not updated at switchover");

    AST_STATUS_ONLY_AT_MUX: assert property (@(posedge clk_i) disable iff (rst_i)
        !pcc_done && !mcs_done |=> $stable(cpu_sub_reg) && $stable(src_sts_reg))
        else $error("status moved outside switchover");

    AST_MCS_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
        mcs_start |-> mcs_load == (src_sts_reg ? MCS_DOWN_CLKS : MCS_UP_CLKS))
        else $error("main source delay wrong");

    AST_MCS_APPLY: assert property (@(posedge clk_i) disable iff (rst_i)
        mcs_start && MCS_UP_CLKS == 2 && !src_sts_reg |=> !src_sts_reg ##2 src_sts_reg)
        else $error("main source switch not after delay");

    AST_HS_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        hs_used_reg |=> $stable(hs_sel_reg))
        else $error("hs_system_select changed twice");

    AST_HS_BEFORE_MAIN: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(src_sts_reg) |-> hs_sel_reg)
        else $error("high-speed source without hs_system_select");

    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    COV_TO_SUB: cover property (@(posedge clk_i) disable iff (rst_i) $rose(cpu_sub_reg));
    COV_FROM_SUB: cover property (@(posedge clk_i) disable iff (rst_i) $fell(cpu_sub_reg));
    COV_TO_HS: cover property (@(posedge clk_i) disable iff (rst_i) $rose(src_sts_reg));
    COV_DIV_CHANGE: cover property (@(posedge clk_i) disable iff (rst_i) pcc_done && !cpu_sub_reg && !req_sub_reg);
endmodule : ccs_clock_switch

// file: tb/ccs_clock_switch_tb.sv
// Self-checking bench for the CPU clock switch: registers, switchover delays and status bits
`timescale 1ns/1ns
`include "ccs_defs.svh"
module ccs_clock_switch_tb;
    import ccs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Short sub clock keeps the main to sub delay at a few cycles
    localparam int FXP = 10000000;
    localparam int FSUB = 5000000;
    localparam int FRH = 8000;
    localparam int FXH = 10000;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic osc_stable = 1'b0;
    ccs_osc_ctrl_type osc_ctrl_o;
    logic hs_system_select_o;
    ccs_clk_state_type clk_state_o;
    int err_count = 0;
    int cmp_count = 0;
    int cyc_count = 0;
    logic [31:0] rd;

    always #50 clk_i = ~clk_i;

    ccs_clock_switch #(.FXP_HZ(FXP), .FSUB_HZ(FSUB), .FRH_KHZ(FRH), .FXH_KHZ(FXH)) i_ccs_clock_switch (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .internal_osc_stable_i(osc_stable), .osc_ctrl_o(osc_ctrl_o), .hs_system_select_o(hs_system_select_o),
        .clk_state_o(clk_state_o));

    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask : close_out

    // A hang counts as a mismatch and still reaches the verdict
    always @(posedge clk_i)
    begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 20000)
        begin
            err_count = err_count + 1;
            close_out();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("BAD %s expected %h seen %h", name, exp, got);
            end
        end
    endtask : chk

    // Classic single cycle; the request stands until ack is sampled high
    task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we <= we;
            wb_adr <= adr;
            wb_sel <= sel;
            wb_wdat <= dat;
            do
            begin
                @(posedge clk_i);
                n = n + 1;
            end
            while (wb_ack_o !== 1'b1 && n < 50);
            // A missing ack counts as a mismatch rather than passing silently
            if (n >= 50)
            begin
                err_count = err_count + 1;
                $display("BAD wb_ack expected 1 seen %b", wb_ack_o);
            end
            rd = wb_dat_o;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            wb_we <= 1'b0;
        end
    endtask : wb_xfer

    task wr(input logic [7:0] adr, input logic [7:0] dat);
        begin
            wb_xfer(1'b1, adr, {24'h00_0000, dat}, 4'hF);
        end
    endtask : wr

    task rd_chk(input string name, input logic [7:0] adr, input logic [7:0] exp);
        begin
            wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF);
            chk(name, {24'h00_0000, exp}, rd);
        end
    endtask : rd_chk

    // Called right after the landing edge; the change is due N+1 edges later
    task wait_chg(input string name, input int n_old);
        logic [4:0] old;
        int cnt;
        begin
            old = clk_state_o;
            cnt = 0;
            do
            begin
                @(posedge clk_i);
                #1;
                cnt = cnt + 1;
            end
            while (clk_state_o === old && cnt < 1000);
            chk(name, n_old + 1, cnt);
        end
    endtask : wait_chg

    function int sub_delay(input int d);
        return (2 * FXP + (FSUB << d) - 1) / (FSUB << d);
    endfunction : sub_delay

    ////////////////////////////////////////////////////////////////////////////
    task test_reset_regs;
        begin
            chk("osc_ctrl reset", 32'h0000_0002, osc_ctrl_o);
            chk("clk_state reset", 32'h0000_0000, clk_state_o);
            rd_chk("pcc reset", `CCS_OFF_PCC, 8'h00);
            rd_chk("moc reset", `CCS_OFF_MOC, 8'h80);
            rd_chk("rcm stable", `CCS_OFF_RCM, 8'h80);
            rd_chk("unmapped", 8'h20, 8'h00);
        end
    endtask : test_reset_regs

    task test_osc_bits;
        begin
            wr(`CCS_OFF_CLOCK_OP_MODE_REG, 8'hD0);
            wr(`CCS_OFF_MOC, 8'h00);
            wr(`CCS_OFF_RCM, 8'h01);
            wb_xfer(1'b1, `CCS_OFF_MOC, 32'h0000_0080, 4'hE);
            wr(8'h20, 8'hFF);
            #1;
            chk("osc_ctrl bits", 32'h0000_001D, osc_ctrl_o);
            rd_chk("clock_op_mode_reg", `CCS_OFF_CLOCK_OP_MODE_REG, 8'hD0);
            rd_chk("moc", `CCS_OFF_MOC, 8'h00);
            rd_chk("rcm", `CCS_OFF_RCM, 8'h81);
            wr(`CCS_OFF_RCM, 8'h00);
        end
    endtask : test_osc_bits

    task test_divider;
        int d;
        begin
            for (d = 0; d < 5; d++)
            begin
                wr(`CCS_OFF_PCC, 8'((d + 1) % 5));
                wait_chg("div delay", 16 >> d);
                chk("div field", 32'((d + 1) % 5), clk_state_o.main_divider_field);
            end
        end
    endtask : test_divider

    task test_sub;
        begin
            wr(`CCS_OFF_PCC, 8'h10);
            wait_chg("main to sub div0", sub_delay(0));
            chk("sub status", 32'h0000_0010, clk_state_o);
            rd_chk("pcc on sub", `CCS_OFF_PCC, 8'h30);
            wr(`CCS_OFF_PCC, 8'h02);
            wait_chg("leave sub", 2);
            chk("back on main div2", 32'h0000_0002, clk_state_o);
            wr(`CCS_OFF_PCC, 8'h12);
            wait_chg("main to sub div2", sub_delay(2));
            wr(`CCS_OFF_PCC, 8'h00);
            wait_chg("leave sub div0", 2);
            chk("main div0", 32'h0000_0000, clk_state_o);
        end
    endtask : test_sub

    task test_main_src;
        begin
            wr(`CCS_OFF_MCM, 8'h01);
            repeat (10) @(posedge clk_i);
            #1;
            chk("no switch without hs", 32'h0000_0000, clk_state_o.main_src_status);
            wr(`CCS_OFF_MCM, 8'h05);
            wait_chg("to hs system", 1 + (2 * FRH) / FXH);
            chk("src status", 32'h0000_0001, clk_state_o.main_src_status);
            rd_chk("mcm on hs", `CCS_OFF_MCM, 8'h07);
            // Round trip through sub while the main system clock is the high-speed one
            wr(`CCS_OFF_PCC, 8'h10);
            wait_chg("hs main to sub", sub_delay(0));
            wr(`CCS_OFF_PCC, 8'h00);
            wait_chg("sub to hs main", 2);
            chk("on hs main", 32'h0000_0008, clk_state_o);
            wr(`CCS_OFF_MCM, 8'h00);
            wait_chg("to internal", 1 + (2 * FXH) / FRH);
            chk("hs kept", 32'h0000_0001, hs_system_select_o);
            rd_chk("mcm back", `CCS_OFF_MCM, 8'h04);
        end
    endtask : test_main_src

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        osc_stable <= 1'b1;
        repeat (4) @(posedge clk_i);
        test_reset_regs();
        test_osc_bits();
        test_divider();
        test_sub();
        test_main_src();
        close_out();
    end
endmodule : ccs_clock_switch_tb
